// file: bench/lpt_rx_model.sv
// receiver model: rebuilds words from the lanes, framed by the clock lane
`timescale 1ns/100ps

module lpt_rx_model #(
   parameter int LANES = 4
) (
   input wire logic mclk_i,             // bit clock
   input wire logic [LANES-1:0] lane_i, // serial data lanes
   input wire logic lanes_off_i,        // lanes tri-stated
   input wire logic fwd_i,              // forwarded clock lane
   input wire logic clk_off_i,          // clock lane tri-stated
   output logic [LANES*7-1:0] word_o,   // last whole word
   output int frames_o                  // whole words seen
);
   logic fwd_q = 1'b0;
   logic synced = 1'b0;
   logic [2:0] slot = 3'h0;
   logic [LANES*7-1:0] acc = '0;

   initial begin
      word_o = '0;
      frames_o = 0;
   end

   // ****************************************************
   // slot tracking and word assembly
   // ****************************************************
   // a released link loses framing; it is found again on the next clock rise
   always @(posedge mclk_i) begin
      if (lanes_off_i || clk_off_i) begin
         synced = 1'b0;
      end else begin
         if (fwd_i === 1'b1 && fwd_q === 1'b0) begin
            slot = 3'h5;
            synced = 1'b1;
         end
         for (int l = 0; l < LANES; l++) begin
            acc[l*7+slot] = lane_i[l];
         end
         if (synced && slot == 3'h6) begin
            word_o = acc;
            frames_o++;
         end
         slot = (slot == 3'h6) ? 3'h0 : slot + 3'h1;
      end
      fwd_q = fwd_i;
   end
endmodule

// file: bench/lvds_pixel_serializer_tx_tb.sv
// self-checking bench for the pixel serializer transmitter
`timescale 1ns/100ps

module lvds_pixel_serializer_tx_tb;
   localparam int LOCK_T = 20;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pclk = 1'b0;
   logic pclk_run = 1'b1;
   logic power_down_n_i = 1'b0;
   logic strobe_edge_select_i = 1'b1;
   logic [27:0] cur_w = '0;
   logic [27:0] word_a = '0;
   logic [27:0] word_b = '0;
   logic [3:0] lanes;
   logic [2:0] lanes_n;
   logic oe_w, coe_w, fwd, oe_n3, coe_n3, fwd_n;
   logic [27:0] rx_w;
   logic [20:0] rx_wn;
   int frames, frames_n;
   int err_total = 0;
   int total_checks = 0;

   always #5 mclk_i = ~mclk_i;
   initial begin
      #3;
      forever #15 pclk = pclk_run ? ~pclk : 1'b0;
   end
   // word a stands at each rising edge, word b at each falling edge
   always @(posedge pclk) cur_w <= #1 word_b;
   always @(negedge pclk) cur_w <= #1 word_a;

   lpt_tx_top #(.WIDE(1'b1), .LOCK_CYCLES(LOCK_T)) dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .pixel_clock_in_i(pclk),
      .power_down_n_i(power_down_n_i),
      .strobe_edge_select_i(strobe_edge_select_i),
      .red_i(cur_w[7:0]), .green_i(cur_w[15:8]), .blue_i(cur_w[23:16]),
      .line_sync_i(cur_w[24]), .frame_sync_i(cur_w[25]),
      .pixel_valid_i(cur_w[26]), .ctrl_spare_i(cur_w[27]),
      .serial_lane_out_o(lanes), .serial_lane_oe_n_o(oe_w),
      .forwarded_clock_out_o(fwd), .forwarded_clock_oe_n_o(coe_w));
   lpt_tx_top #(.WIDE(1'b0), .LOCK_CYCLES(LOCK_T)) dut_narrow (
      .mclk_i(mclk_i), .rst_i(rst_i), .pixel_clock_in_i(pclk),
      .power_down_n_i(power_down_n_i),
      .strobe_edge_select_i(strobe_edge_select_i),
      .red_i(cur_w[5:0]), .green_i(cur_w[13:8]), .blue_i(cur_w[21:16]),
      .line_sync_i(cur_w[24]), .frame_sync_i(cur_w[25]),
      .pixel_valid_i(cur_w[26]), .ctrl_spare_i(cur_w[27]),
      .serial_lane_out_o(lanes_n), .serial_lane_oe_n_o(oe_n3),
      .forwarded_clock_out_o(fwd_n), .forwarded_clock_oe_n_o(coe_n3));
   lpt_rx_model #(.LANES(4)) rx (.mclk_i(mclk_i), .lane_i(lanes),
      .lanes_off_i(oe_w), .fwd_i(fwd), .clk_off_i(coe_w),
      .word_o(rx_w), .frames_o(frames));
   lpt_rx_model #(.LANES(3)) rx_n (.mclk_i(mclk_i), .lane_i(lanes_n),
      .lanes_off_i(oe_n3), .fwd_i(fwd_n), .clk_off_i(coe_n3),
      .word_o(rx_wn), .frames_o(frames_n));

   // ****************************************************
   // shared helpers
   // ****************************************************
   task automatic check(input string what, input logic [27:0] seen,
                        input logic [27:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick();
      @(posedge mclk_i);
      #1;
   endtask

   task automatic wait_frames(input int n);
      int start;
      int start_n;
      int k;
      start = frames;
      start_n = frames_n;
      k = 0;
      while ((frames < start + n || frames_n < start_n + n)
             && k < 100 * n) begin
         tick();
         k++;
      end
      check("frame arrival", 28'(frames >= start + n), 28'h000_0001);
      check("frames n", 28'(frames_n >= start_n + n), 28'h000_0001);
      if (k >= 100 * n) complete_run();
   endtask

   function automatic logic [27:0] narrow(input logic [27:0] w);
      return {7'h00, w[26:24], w[21:16], w[13:8], w[5:0]};
   endfunction

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic power_up();
      int n;
      tick();
      power_down_n_i = 1'b1;
      n = 0;
      while (fwd !== 1'b1 && n < 200) begin
         tick();
         n++;
      end
      // two sync edges, one idle cycle, the lock wait, one output register
      check("lock wait", 28'(n), 28'(LOCK_T + 4));
      if (n >= 200) complete_run();
   endtask

   task automatic power_down(input int k);
      repeat (k) tick();
      power_down_n_i = 1'b0;
      repeat (5) tick();
      check("oe off", {26'h0, oe_w, coe_w}, 28'h000_0003);
      check("oe off narrow", {26'h0, oe_n3, coe_n3}, 28'h000_0003);
      check("parked", {23'h0, lanes, fwd}, 28'h000_0000);
      check("parked narrow", {24'h0, lanes_n, fwd_n}, 28'h000_0000);
   endtask

   task automatic edge_select();
      word_a = 28'h5a5_a5a5;
      word_b = 28'ha5a_5a5a;
      tick();
      strobe_edge_select_i = 1'b1;
      wait_frames(5);
      check("rising edge word", rx_w, 28'h5a5_a5a5);
      tick();
      strobe_edge_select_i = 1'b0;
      wait_frames(5);
      check("falling edge word", rx_w, 28'ha5a_5a5a);
   endtask

   task automatic lane_map();
      logic [27:0] tbl [8] = '{28'h800_0000, 28'h400_0000, 28'h200_0000,
         28'h100_0000, 28'h000_00ff, 28'h000_ff00, 28'h0ff_0000,
         28'h000_0001};
      for (int i = 0; i < 8; i++) begin
         word_a = tbl[i];
         word_b = tbl[i];
         wait_frames(5);
         check("wide word", rx_w, tbl[i]);
         check("narrow word", {7'h00, rx_wn}, narrow(tbl[i]));
      end
   endtask

   task automatic fwd_shape();
      int rises;
      int highs;
      logic prev;
      rises = 0;
      highs = 0;
      prev = fwd;
      repeat (70) begin
         tick();
         if (fwd === 1'b1) highs++;
         if (fwd === 1'b1 && prev === 1'b0) rises++;
         prev = fwd;
      end
      check("clock lane rises", 28'(rises), 28'h000_000a);
      check("clock lane high slots", 28'(highs), 28'h000_0028);
   endtask

   task automatic pd_any_slot();
      word_a = 28'h0c3_9e71;
      word_b = 28'h0c3_9e71;
      for (int k = 0; k < 7; k++) begin
         power_down(k);
         repeat (12) tick();
         power_up();
         wait_frames(5);
         check("word after relock", rx_w, 28'h0c3_9e71);
      end
   endtask

   task automatic clock_stop();
      power_down(3);
      repeat (12) tick();
      pclk_run = 1'b0;
      repeat (30) tick();
      check("stopped oe", {26'h0, oe_w, coe_w}, 28'h000_0003);
      check("stopped lanes", {23'h0, lanes, fwd}, 28'h000_0000);
      pclk_run = 1'b1;
      repeat (12) tick();
      word_a = 28'h3f0_0f0f;
      word_b = 28'h3f0_0f0f;
      power_up();
      wait_frames(5);
      check("word after restart", rx_w, 28'h3f0_0f0f);
   endtask

   initial begin
      repeat (20) @(posedge mclk_i);
      #1;
      rst_i = 1'b0;
      repeat (3) tick();
      check("oe at start", {26'h0, oe_w, coe_w}, 28'h000_0003);
      power_up();
      edge_select();
      lane_map();
      fwd_shape();
      pd_any_slot();
      clock_stop();
      complete_run();
   end
endmodule

// file: include/lpt_params.svh
// constants for the pixel serializer transmitter
`ifndef LPT_PARAMS_SVH
`define LPT_PARAMS_SVH

// ****************************************************
// word and lane geometry
// ****************************************************
`define LPT_NARROW_WORD_BITS 21
`define LPT_WIDE_WORD_BITS 28
`define LPT_NARROW_COLOR_BITS 6
`define LPT_WIDE_COLOR_BITS 8
`define LPT_NARROW_LANES 3
`define LPT_WIDE_LANES 4

// ****************************************************
// serial framing
// ****************************************************
`define LPT_SLOTS 7
`define LPT_SLOT_FIRST 3'h0
`define LPT_SLOT_LAST 3'h6
// forwarded clock shape per slot, bit n is slot n
`define LPT_FWD_PATTERN 7'h63

// ****************************************************
// timing
// ****************************************************
`define LPT_CLK_MHZ 100
`define LPT_LOCK_TIME_MS 10
`define LPT_LOCK_CYCLES (`LPT_LOCK_TIME_MS * 1000 * `LPT_CLK_MHZ)

`endif

// file: include/lpt_pkg.sv
// types for the pixel serializer transmitter
package lpt_pkg;

   // ****************************************************
   // power and lock state
   // ****************************************************
   typedef enum logic [1:0] {
      LPT_OFF     = 2'h0,
      LPT_LOCKING = 2'h1,
      LPT_RUN     = 2'h2
   } lpt_pwr_type;

endpackage

// file: src/lpt_capture.sv
// pixel clock domain: strobe edge capture and two word bank
`timescale 1ns/100ps
`include "lpt_params.svh"

module lpt_capture #(
   parameter int WORD_BITS = `LPT_WIDE_WORD_BITS
) (
   input wire logic pclk_i,                 // pixel clock
   input wire logic power_down_n_i,         // raw power-down pin
   input wire logic strobe_edge_select_i,   // 1 rising, 0 falling
   input wire logic [WORD_BITS-1:0] word_i, // parallel pixel word
   output logic toggle_o,                   // flips per stored word
   output logic [WORD_BITS-1:0] bank0_o,    // word bank entry 0
   output logic [WORD_BITS-1:0] bank1_o     // word bank entry 1
);

   logic pd_p;
   logic sel_q;
   logic wr_ptr;
   logic [WORD_BITS-1:0] neg_word;
   logic [WORD_BITS-1:0] next_word;

   // ****************************************************
   // pin synchronisers on the pixel clock
   // ****************************************************
   lpt_sync #(.W(2)) u_psync (
      .clk_i(pclk_i),
      .rst_i(1'h0),
      .async_i({power_down_n_i, strobe_edge_select_i}),
      .sync_o({pd_p, sel_q})
   );

   // falling edge sample, moved to the bank on the next rise
   always_ff @(negedge pclk_i) begin
      neg_word <= word_i;
   end

   assign next_word = sel_q ? word_i : neg_word;

   // ****************************************************
   // bank write; the clock keeps running while enabled
   // ****************************************************
   always_ff @(posedge pclk_i) begin
      if (!pd_p) begin
         wr_ptr <= 1'h0;
         toggle_o <= 1'h0;
         bank0_o <= '0;
         bank1_o <= '0;
      end else begin
         wr_ptr <= ~wr_ptr;
         toggle_o <= ~toggle_o;
         if (wr_ptr) begin
            bank1_o <= next_word;
         end else begin
            bank0_o <= next_word;
         end
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   rise_capture_a: assert property (
      @(posedge pclk_i) disable iff (!pd_p)
      sel_q |=> (($past(wr_ptr) ? bank1_o : bank0_o) == $past(word_i)))
      else $error("rising strobe word not stored");

   fall_capture_a: assert property (
      @(posedge pclk_i) disable iff (!pd_p)
      !sel_q |=> (($past(wr_ptr) ? bank1_o : bank0_o) == $past(neg_word)))
      else $error("falling strobe word not stored");

   word_toggle_a: assert property (
      @(posedge pclk_i) disable iff (!pd_p)
      pd_p ##1 pd_p |-> toggle_o != $past(toggle_o))
      else $error("handoff toggle missed a pixel period");

endmodule

// file: src/lpt_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps

module lpt_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,          // destination clock
   input wire logic rst_i,          // synchronous reset, active high
   input wire logic [W-1:0] async_i, // level from another domain
   output logic [W-1:0] sync_o      // synchronised level
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// file: src/lpt_tx_top.sv
// pixel serializer transmitter top: lock timing and lane framing
`timescale 1ns/100ps
`include "lpt_params.svh"

// Operation
// - select high captures on rising pixel edge
// - select low or open captures falling edge; the code has no pull-down, so an open pin selects neither edge
// - power-down low tri-states all serial outputs
// - narrow variant takes 21-bit word
// - narrow variant drives three data lanes
// - sync and enable bits serialized like colour
// - bit slots placed by seven-times bit clock
// - clock stop needs power-down; loop held off
// - outputs start toggling 10 ms after release
// - power-down accepted at any moment
// - wide variant takes 28-bit word
// - wide variant drives four data lanes
module lpt_tx_top #(
   parameter bit WIDE = 1'b1,
   parameter int LOCK_CYCLES = `LPT_LOCK_CYCLES,
   parameter int COLOR_BITS =
      WIDE ? `LPT_WIDE_COLOR_BITS : `LPT_NARROW_COLOR_BITS,
   parameter int LANES = WIDE ? `LPT_WIDE_LANES : `LPT_NARROW_LANES
) (
   input wire logic mclk_i,                    // seven-times bit clock
   input wire logic rst_i,                     // sync reset, high
   input wire logic pixel_clock_in_i,          // pixel clock
   input wire logic power_down_n_i,            // low powers down
   input wire logic strobe_edge_select_i,      // 1 rising, 0 falling
   input wire logic [COLOR_BITS-1:0] red_i,    // red colour bits
   input wire logic [COLOR_BITS-1:0] green_i,  // green colour bits
   input wire logic [COLOR_BITS-1:0] blue_i,   // blue colour bits
   input wire logic line_sync_i,               // horizontal sync
   input wire logic frame_sync_i,              // vertical sync
   input wire logic pixel_valid_i,             // data enable
   input wire logic ctrl_spare_i,              // fourth control, wide
   output logic [LANES-1:0] serial_lane_out_o, // serial data lanes
   output logic serial_lane_oe_n_o,            // lanes enable, low on
   output logic forwarded_clock_out_o,         // forwarded clock lane
   output logic forwarded_clock_oe_n_o         // clock enable, low on
);

   localparam int WORD_BITS =
      WIDE ? `LPT_WIDE_WORD_BITS : `LPT_NARROW_WORD_BITS;
   localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
   localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);
   localparam logic [`LPT_SLOTS-1:0] FWD_PATTERN = `LPT_FWD_PATTERN;

   logic [WORD_BITS-1:0] pix_word;
   logic tog_p;
   logic [WORD_BITS-1:0] bank0;
   logic [WORD_BITS-1:0] bank1;
   logic pd_q;
   logic tog_q;
   lpt_pkg::lpt_pwr_type state;
   logic [CNT_W-1:0] lock_cnt;
   logic tog_seen;
   logic rd_ptr;
   logic take;
   logic [WORD_BITS-1:0] pend_word;
   logic [WORD_BITS-1:0] cur_word;
   logic [2:0] slot;
   logic run;
   logic cur_bit0;
   logic [LANES-1:0] exp_lanes;

   // picks the word bit carried by a lane in a slot
   function automatic logic lane_bit(
      input logic [WORD_BITS-1:0] w,
      input int lane,
      input logic [2:0] s
   );
      return w[lane * `LPT_SLOTS + int'(s)];
   endfunction

   // ****************************************************
   // parallel word assembly
   // ****************************************************
   generate
      if (WIDE) begin : g_wide
         assign pix_word = {ctrl_spare_i, pixel_valid_i, frame_sync_i,
            line_sync_i, blue_i, green_i, red_i};
      end else begin : g_narrow
         assign pix_word = {pixel_valid_i, frame_sync_i,
            line_sync_i, blue_i, green_i, red_i};
      end
   endgenerate

   // ****************************************************
   // pixel clock side
   // ****************************************************
   lpt_capture #(.WORD_BITS(WORD_BITS)) u_capture (
      .pclk_i(pixel_clock_in_i),
      .power_down_n_i(power_down_n_i),
      .strobe_edge_select_i(strobe_edge_select_i),
      .word_i(pix_word),
      .toggle_o(tog_p),
      .bank0_o(bank0),
      .bank1_o(bank1)
   );

   // ****************************************************
   // crossings into the bit clock
   // ****************************************************
   lpt_sync #(.W(2)) u_msync (
      .clk_i(mclk_i),
      .rst_i(rst_i),
      .async_i({power_down_n_i, tog_p}),
      .sync_o({pd_q, tog_q})
   );

   assign take = tog_q != tog_seen;
   assign run = state == lpt_pkg::LPT_RUN;

   // ****************************************************
   // loop lock state
   // ****************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state <= lpt_pkg::LPT_OFF;
      end else if (!pd_q) begin
         state <= lpt_pkg::LPT_OFF;
      end else begin
         case (state)
            lpt_pkg::LPT_OFF: begin
               state <= lpt_pkg::LPT_LOCKING;
            end
            lpt_pkg::LPT_LOCKING: begin
               if (lock_cnt == LOCK_LAST) begin
                  state <= lpt_pkg::LPT_RUN;
               end
            end
            lpt_pkg::LPT_RUN: begin
               state <= lpt_pkg::LPT_RUN;
            end
            default: begin
               state <= lpt_pkg::LPT_OFF;
            end
         endcase
      end
   end

   // lock wait only counts with power-down released
   always_ff @(posedge mclk_i) begin
      if (rst_i || state != lpt_pkg::LPT_LOCKING) begin
         lock_cnt <= '0;
      end else begin
         lock_cnt <= lock_cnt + CNT_W'(1);
      end
   end

   // ****************************************************
   // word handoff from the pixel domain
   // ****************************************************
   // bank is read only after its toggle crossed, so it is stable
   always_ff @(posedge mclk_i) begin
      if (rst_i || !pd_q) begin
         tog_seen <= 1'h0;
         rd_ptr <= 1'h0;
      end else if (take) begin
         tog_seen <= tog_q;
         rd_ptr <= ~rd_ptr;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pend_word <= '0;
      end else if (take) begin
         pend_word <= rd_ptr ? bank1 : bank0;
      end
   end

   // ****************************************************
   // slot counter and frame word
   // ****************************************************
   // a word that arrives mid-frame waits for the next frame start
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run) begin
         slot <= `LPT_SLOT_FIRST;
         cur_word <= '0;
      end else if (slot == `LPT_SLOT_LAST) begin
         slot <= `LPT_SLOT_FIRST;
         cur_word <= pend_word;
      end else begin
         slot <= slot + 3'h1;
      end
   end

   // ****************************************************
   // serial outputs
   // ****************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run) begin
         serial_lane_out_o <= '0;
         forwarded_clock_out_o <= 1'h0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            serial_lane_out_o[l] <= lane_bit(cur_word, l, slot);
         end
         forwarded_clock_out_o <= FWD_PATTERN[slot];
      end
   end

   // lane count is fixed by the variant
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         serial_lane_oe_n_o <= 1'h1;
         forwarded_clock_oe_n_o <= 1'h1;
      end else begin
         serial_lane_oe_n_o <= !pd_q;
         forwarded_clock_oe_n_o <= !pd_q;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   assign cur_bit0 = lane_bit(cur_word, 0, slot);

   // every lane, not just lane 0, so a swapped lane index shows up
   always_comb begin
      exp_lanes = '0;
      for (int l = 0; l < LANES; l++) begin
         exp_lanes[l] = lane_bit(cur_word, l, slot);
      end
   end

   sequence fwd_low_s;
      !forwarded_clock_out_o [*3];
   endsequence

   sequence fwd_high_s;
      forwarded_clock_out_o [*4];
   endsequence

   pd_tristate_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !pd_q |=> serial_lane_oe_n_o && forwarded_clock_oe_n_o)
      else $error("outputs driven during power-down");

   pd_enable_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      pd_q |=> !serial_lane_oe_n_o && !forwarded_clock_oe_n_o)
      else $error("outputs not enabled after release");

   pd_clears_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !pd_q |=> !run ##1 (slot == 3'h0 && lock_cnt == '0))
      else $error("power-down did not clear lock and slot");

   lock_wait_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $rose(run) |-> $past(lock_cnt) == LOCK_LAST
         && $past(state) == lpt_pkg::LPT_LOCKING)
      else $error("lock reached before the wait ended");

   quiet_unlocked_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !run |=> !forwarded_clock_out_o && serial_lane_out_o == '0)
      else $error("outputs toggled before lock");

   slot_wrap_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      run && slot == `LPT_SLOT_LAST ##1 run |-> slot == `LPT_SLOT_FIRST)
      else $error("slot counter did not wrap after seven");

   word_load_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      run && slot == `LPT_SLOT_LAST ##1 run |-> cur_word == $past(pend_word))
      else $error("frame word not loaded at frame start");

   lane_map_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      run |=> serial_lane_out_o[0] == $past(cur_bit0))
      else $error("lane bit does not match word slot");

   fwd_shape_a: assert property (
      @(posedge mclk_i) disable iff (rst_i || !run)
      $fell(forwarded_clock_out_o) |-> fwd_low_s ##1 fwd_high_s)
      else $error("forwarded clock lost its shape");

   lock_hold_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      state == lpt_pkg::LPT_LOCKING && lock_cnt != LOCK_LAST |=> !run)
      else $error("lock wait cut short");

   off_hold_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !pd_q |=> state == lpt_pkg::LPT_OFF)
      else $error("loop not held off in power-down");

   slot_step_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      run && slot != `LPT_SLOT_LAST ##1 run |-> slot == $past(slot) + 3'h1)
      else $error("slot counter skipped a bit slot");

   lane_all_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      run |=> serial_lane_out_o == $past(exp_lanes))
      else $error("a lane bit does not match its word slot");

endmodule
